//--- shared/dlo_pkg.sv
// constants, register map and gain helpers for the limiter block.
// assumes 24-bit signed samples and 9-bit registers.
package dlo_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register map
    localparam logic [6:0] ADDR_POWER_ONE = 7'h01;
    localparam logic [6:0] ADDR_LIM_TIMING = 7'h18;
    localparam logic [6:0] ADDR_LIM_LEVEL = 7'h19;
    localparam logic [6:0] ADDR_BYP_ATTN = 7'h28;
    localparam logic [6:0] ADDR_OUT_STAGE = 7'h31;
    localparam logic [6:0] ADDR_SPK_MIX = 7'h32;
    localparam logic [6:0] ADDR_SPK_VOL = 7'h36;

    localparam logic [8:0] RST_POWER_ONE = 9'h000;
    localparam logic [8:0] RST_LIM_TIMING = 9'h032;
    localparam logic [8:0] RST_LIM_LEVEL = 9'h000;
    localparam logic [8:0] RST_BYP_ATTN = 9'h000;
    localparam logic [8:0] RST_OUT_STAGE = 9'h000;
    localparam logic [8:0] RST_SPK_MIX = 9'h001;
    localparam logic [8:0] RST_SPK_VOL = 9'h039;

    // field positions
    localparam int ATK_LSB = 0;
    localparam int DCY_LSB = 4;
    localparam int LIMITER_ENABLE_BIT = 8;
    localparam int BOOST_LSB = 0;
    localparam int LVL_LSB = 4;
    localparam int SPK_BOOST_BIT = 2;
    localparam int MONO_BOOST_BIT = 3;
    localparam int DCBUF_BIT = 8;
    localparam int DAC_MIX_BIT = 0;
    localparam int BYP_MIX_BIT = 1;
    localparam int MIC_MIX_BIT = 5;
    localparam int SPK_ATTN_BIT = 1;
    localparam int ZC_BIT = 7;
    localparam int MUTE_BIT = 6;
    localparam int VOL_LSB = 0;

    ////////////////////////////////////////////////////////////////////////////
    // gains in 1/64 dB units
    localparam int UNITS_PER_DB = 64;
    localparam int UNITS_PER_6DB = 384;
    localparam int UNITS_PER_HALF_DB = 32;
    localparam logic [3:0] BOOST_MAX_CODE = 4'hc;
    localparam logic [3:0] RATE_SAT_CODE = 4'hb;
    localparam logic [2:0] LVL_MAX_IDX = 3'h5;
    localparam logic [5:0] VOL_ZERO_DB_CODE = 6'h39;
    localparam logic signed [15:0] BYP_ATTN_UNITS = -16'sh0280;
    localparam logic signed [16:0] HEADROOM_UNITS = 17'sh0300;
    // 1/64 dB units, 8 fraction bits, 48 dB cap
    localparam logic [19:0] ATT_MAX = 20'hc_0000;

    // per 6 dB at the reference rate
    localparam real REF_RATE_HZ = 44100.0;
    localparam real ATK_BASE_TIME_US = 94.0;
    localparam real DCY_BASE_TIME_US = 750.0;
    localparam logic [19:0] ATK_INC_BASE =
        20'(int'(384.0 * 256.0 / (ATK_BASE_TIME_US * 1.0e-6 * REF_RATE_HZ)));
    localparam logic [19:0] DCY_INC_BASE =
        20'(int'(384.0 * 256.0 / (DCY_BASE_TIME_US * 1.0e-6 * REF_RATE_HZ)));

    localparam int ZC_TIMEOUT_DEFAULT = 2097152;

    // Q15 gain of each 0.5 dB step in 6 dB
    function automatic logic [15:0] gain_step(input logic [3:0] idx);
        unique case (idx)
            4'h0: return 16'h8000;
            4'h1: return 16'h78d7;
            4'h2: return 16'h7215;
            4'h3: return 16'h6bb3;
            4'h4: return 16'h65ad;
            4'h5: return 16'h5ffd;
            4'h6: return 16'h5a9e;
            4'h7: return 16'h558c;
            4'h8: return 16'h50c3;
            4'h9: return 16'h4c3f;
            4'ha: return 16'h47fb;
            default: return 16'h43f4;
        endcase
    endfunction

    // magnitude thresholds, -0.5 to -6.5 dB
    function automatic logic [23:0] level_thr(input logic [2:0] idx);
        unique case (idx)
            3'h0: return 24'h78_d692;
            3'h1: return 24'h6b_b2d6;
            3'h2: return 24'h5f_fc62;
            3'h3: return 24'h55_8c3c;
            3'h4: return 24'h4c_3ea2;
            3'h5: return 24'h43_f3f0;
            default: return 24'h3c_9038;
        endcase
    endfunction

endpackage : dlo_pkg

//--- tb/dlo_limiter_output_props.sv
// concurrent checks on the limiter block ports
// assumes binding into dlo_limiter_output
module dlo_limiter_output_props
    import dlo_pkg::*;
#(
    parameter int ZC_TIMEOUT_CYCLES = ZC_TIMEOUT_DEFAULT
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // register writes
    input wire logic reg_wr_en,
    input wire logic [6:0] reg_addr,
    input wire logic [8:0] reg_wdata,
    // sample path
    input wire logic signed [23:0] in_sample,
    input wire logic out_valid,
    input wire logic signed [23:0] out_sample,
    input wire logic signed [23:0] speaker_out_positive,
    input wire logic signed [23:0] speaker_out_negative,
    // stage controls
    input wire logic speaker_stage_gain_boost,
    input wire logic mono_stage_gain_boost,
    input wire logic dc_shift_buffer_enable
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [8:0] tim_r, lvl_r, mix_r, vol_r;
    logic [1:0] quiet_r;
    logic signed [23:0] prev_in_r;
    logic [1:0] sh;
    logic boost_known, settled;
    ////////////////////////////////////////////////////////////////////////////
    // settled: two quiet edges
    always_ff @(posedge sys_clk) begin
        prev_in_r <= in_sample;
        if (rst) begin
            tim_r <= RST_LIM_TIMING;
            lvl_r <= RST_LIM_LEVEL;
            mix_r <= RST_SPK_MIX;
            vol_r <= RST_SPK_VOL;
            quiet_r <= 2'd3;
        end else begin
            quiet_r <= reg_wr_en ? 2'd0 : ((quiet_r == 2'd3) ? 2'd3 : quiet_r + 2'd1);
            if (reg_wr_en) begin
                case (reg_addr)
                    ADDR_LIM_TIMING: tim_r <= reg_wdata;
                    ADDR_LIM_LEVEL: lvl_r <= reg_wdata;
                    ADDR_SPK_MIX: mix_r <= reg_wdata;
                    ADDR_SPK_VOL: vol_r <= reg_wdata;
                    default: ;
                endcase
            end
        end
    end
    assign settled = quiet_r >= 2'd2;
    assign boost_known = lvl_r[3:0] == 4'h0 || lvl_r[3:0] == 4'h6 || lvl_r[3:0] >= BOOST_MAX_CODE;
    assign sh = (lvl_r[3:0] == 4'h0) ? 2'd0 : ((lvl_r[3:0] == 4'h6) ? 2'd1 : 2'd2);
    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    a_neg_mirror: assert property (
        speaker_out_negative == ((speaker_out_positive == 24'sh80_0000) ? 24'sh7f_ffff : -speaker_out_positive))
        else $error("negative output not inverted");
    a_spk_boost: assert property (
        reg_wr_en && reg_addr == ADDR_OUT_STAGE |=> speaker_stage_gain_boost == $past(reg_wdata[SPK_BOOST_BIT]))
        else $error("speaker boost wrong");
    a_mono_boost_hold: assert property (
        !(reg_wr_en && reg_addr == ADDR_OUT_STAGE) |=> $stable(mono_stage_gain_boost))
        else $error("mono boost changed");
    a_dc_buffer: assert property (
        reg_wr_en && reg_addr == ADDR_POWER_ONE ##1 1'b1 |-> dc_shift_buffer_enable == $past(reg_wdata[DCBUF_BIT]))
        else $error("dc buffer enable wrong");
    a_mute_level: assert property (
        out_valid && settled && vol_r[MUTE_BIT] |-> speaker_out_positive == '0 && speaker_out_negative == '0)
        else $error("mute not at mid rail");
    a_boost_gain: assert property (
        out_valid && settled && !tim_r[LIMITER_ENABLE_BIT] && boost_known && prev_in_r[23:20] inside {4'h0, 4'hf}
        |-> out_sample == prev_in_r <<< sh)
        else $error("fixed boost gain wrong");
    a_dac_unity: assert property (
        out_valid && settled && mix_r == RST_SPK_MIX && vol_r == RST_SPK_VOL && !speaker_stage_gain_boost
        && out_sample != 24'sh80_0000 |-> speaker_out_positive == -out_sample)
        else $error("unity speaker path wrong");
    a_half_volume: assert property (
        out_valid && settled && mix_r == RST_SPK_MIX && vol_r == 9'h033 && !speaker_stage_gain_boost
        && !out_sample[0] |-> speaker_out_positive == -(out_sample >>> 1))
        else $error("half volume wrong");
endmodule // dlo_limiter_output_props

bind dlo_limiter_output dlo_limiter_output_props #(.ZC_TIMEOUT_CYCLES(ZC_TIMEOUT_CYCLES)) dlo_limiter_output_props_i (
    .sys_clk(sys_clk), .rst(rst), .reg_wr_en(reg_wr_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .in_sample(in_sample), .out_valid(out_valid), .out_sample(out_sample),
    .speaker_out_positive(speaker_out_positive), .speaker_out_negative(speaker_out_negative),
    .speaker_stage_gain_boost(speaker_stage_gain_boost), .mono_stage_gain_boost(mono_stage_gain_boost),
    .dc_shift_buffer_enable(dc_shift_buffer_enable));

//--- tb/dlo_out_stage_model.sv
// output driver model: bridge level and dc shift misuse
// assumes zero at mid-rail
module dlo_out_stage_model (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // block outputs
    input wire logic signed [23:0] speaker_out_positive,
    input wire logic signed [23:0] speaker_out_negative,
    input wire logic speaker_stage_gain_boost,
    input wire logic mono_stage_gain_boost,
    input wire logic dc_shift_buffer_enable,
    // observed state
    output logic shift_fault,
    output logic signed [24:0] bridge_level
);
    timeunit 1ns;
    timeprecision 1ps;
    // boost without dc shift would clip
    always @(posedge sys_clk) begin
        if (rst) begin
            shift_fault <= 1'b0;
        end else if ((speaker_stage_gain_boost || mono_stage_gain_boost) && !dc_shift_buffer_enable) begin
            shift_fault <= 1'b1;
        end
    end
    // load sees only the difference
    assign bridge_level = 25'(speaker_out_positive) - 25'(speaker_out_negative);
endmodule // dlo_out_stage_model

//--- tb/tb_dlo_limiter_output.sv
// self-checking bench for the limiter block
// assumes a 16-cycle zero-cross timeout
`define CHK(nm, e, g) begin n_compared++; if ((e) !== (g)) begin num_errors++; \
    $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module tb_dlo_limiter_output
    import dlo_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [1:0] mode; logic signed [23:0] oe; logic signed [23:0] pe;} dlo_note_t;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic reg_wr_en = 1'b0, reg_rd_en = 1'b0, timeout_clock_enable = 1'b0, in_valid = 1'b0, rd_seen = 1'b0;
    logic [6:0] reg_addr = '0;
    logic [8:0] reg_wdata = '0, reg_rdata, rexp, r;
    logic signed [23:0] in_sample = '0, bypass_sample = '0, mic2_sample = '0, x;
    logic signed [23:0] out_sample, speaker_out_positive, speaker_out_negative;
    logic out_valid, speaker_stage_gain_boost, mono_stage_gain_boost, dc_shift_buffer_enable, shift_fault;
    logic signed [24:0] bridge_level;
    int num_errors = 0, n_compared = 0, cycles = 0;
    dlo_note_t note;
    dlo_note_t smp_q[$];
    logic [8:0] reg_q[$];
    logic [6:0] addrs[7] = '{ADDR_POWER_ONE, ADDR_LIM_TIMING, ADDR_LIM_LEVEL, ADDR_BYP_ATTN, ADDR_OUT_STAGE,
        ADDR_SPK_MIX, ADDR_SPK_VOL};
    logic [8:0] rsts[7] = '{RST_POWER_ONE, RST_LIM_TIMING, RST_LIM_LEVEL, RST_BYP_ATTN, RST_OUT_STAGE,
        RST_SPK_MIX, RST_SPK_VOL};
    logic [3:0] codes[5] = '{4'h0, 4'h6, 4'hc, 4'hd, 4'hf};
    int shs[5] = '{0, 1, 2, 2, 2};
    logic [8:0] mixes[4] = '{9'h002, 9'h020, 9'h023, 9'h001};
    logic [8:0] vols[3] = '{9'h033, 9'h02d, 9'h03f};
    int vs[3] = '{3, 4, 1};

    dlo_limiter_output #(.ZC_TIMEOUT_CYCLES(16)) dlo_limiter_output_i (.sys_clk, .rst, .reg_wr_en, .reg_rd_en,
        .reg_addr, .reg_wdata, .reg_rdata, .timeout_clock_enable, .in_valid, .in_sample, .bypass_sample,
        .mic2_sample, .out_valid, .out_sample, .speaker_out_positive, .speaker_out_negative,
        .speaker_stage_gain_boost, .mono_stage_gain_boost, .dc_shift_buffer_enable);
    dlo_out_stage_model dlo_out_stage_model_i (.sys_clk, .rst, .speaker_out_positive, .speaker_out_negative,
        .speaker_stage_gain_boost, .mono_stage_gain_boost, .dc_shift_buffer_enable, .shift_fault, .bridge_level);

    initial forever #2 sys_clk = ~sys_clk;

    ////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        if (num_errors == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic wr(input logic [6:0] a, input logic [8:0] d);
        @(negedge sys_clk);
        reg_wr_en = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge sys_clk);
        reg_wr_en = 1'b0;
    endtask

    task automatic rd(input logic [6:0] a, input logic [8:0] e);
        @(negedge sys_clk);
        reg_q.push_back(e);
        reg_rd_en = 1'b1;
        reg_addr = a;
        @(negedge sys_clk);
        reg_rd_en = 1'b0;
    endtask

    // mode 0 exact, 1 ignored, 2 output below oe
    task automatic smp(input logic signed [23:0] s, input logic [1:0] m, input logic signed [23:0] oe, pe);
        @(negedge sys_clk);
        smp_q.push_back('{m, oe, pe});
        in_valid = 1'b1;
        in_sample = s;
        @(negedge sys_clk);
        in_valid = 1'b0;
    endtask

    function automatic logic signed [23:0] rnd();
        return 24'($signed(20'($urandom)));
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    always @(posedge sys_clk) begin
        rd_seen <= reg_rd_en;
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            report_and_stop();
        end
    end

    always @(negedge sys_clk) begin
        if (rd_seen) begin
            rexp = reg_q.pop_front();
            `CHK("reg_rdata", rexp, reg_rdata)
        end
        if (out_valid) begin
            note = smp_q.pop_front();
            if (note.mode == 2'd0) begin
                `CHK("out_sample", note.oe, out_sample)
                `CHK("speaker_out_positive", note.pe, speaker_out_positive)
                `CHK("bridge_level", 25'(note.pe) * 25'sd2, bridge_level)
            end else if (note.mode == 2'd2) begin
                `CHK("limited", 1'b1, out_sample < note.oe)
            end
        end
    end

    initial begin
        void'($urandom(56));
        repeat (6) @(posedge sys_clk);
        @(negedge sys_clk);
        rst = 1'b0;
        foreach (addrs[i]) begin
            rd(addrs[i], rsts[i]);
            r = 9'($urandom) & ((addrs[i] == ADDR_OUT_STAGE) ? 9'h1f3 : 9'h1ff);
            wr(addrs[i], r);
            rd(addrs[i], r);
            wr(addrs[i], rsts[i]);
        end
        rd(7'h00, 9'h000);
        foreach (codes[i]) begin
            wr(ADDR_LIM_LEVEL, {5'h00, codes[i]});
            x = rnd();
            smp(x, 2'd0, x <<< shs[i], -(x <<< shs[i]));
        end
        wr(ADDR_LIM_LEVEL, RST_LIM_LEVEL);
        foreach (mixes[i]) begin
            wr(ADDR_SPK_MIX, mixes[i]);
            bypass_sample = rnd();
            mic2_sample = rnd();
            x = rnd();
            smp(x, 2'd0, x, -((mixes[i][0] ? x : 0) + (mixes[i][1] ? bypass_sample : 0)
                + (mixes[i][5] ? mic2_sample : 0)));
        end
        foreach (vols[i]) begin
            wr(ADDR_SPK_VOL, vols[i]);
            x = rnd() & ~24'sd3;
            smp(x, 2'd0, x, -((x <<< 2) >>> vs[i]));
        end
        wr(ADDR_SPK_VOL, 9'h079);
        smp(x, 2'd0, x, 24'sd0);
        wr(ADDR_SPK_VOL, RST_SPK_VOL);
        wr(ADDR_POWER_ONE, 9'h100);
        wr(ADDR_OUT_STAGE, 9'h00c);
        `CHK("stage_boost", 3'b111, {speaker_stage_gain_boost, mono_stage_gain_boost, dc_shift_buffer_enable})
        x = rnd() & ~24'sd1;
        smp(x, 2'd0, x, x + (x >>> 1));
        wr(ADDR_OUT_STAGE, RST_OUT_STAGE);
        wr(ADDR_POWER_ONE, RST_POWER_ONE);
        x = (rnd() & 24'sh07_fffc) + 24'sd4;
        smp(x, 2'd0, x, -x);
        wr(ADDR_SPK_VOL, 9'h0b3);
        smp(x, 2'd0, x, -x);
        smp(-x, 2'd1, 24'sd0, 24'sd0);
        smp(x, 2'd0, x, -(x >>> 1));
        wr(ADDR_SPK_VOL, 9'h0b9);
        smp(x, 2'd0, x, -(x >>> 1));
        timeout_clock_enable = 1'b1;
        repeat (20) @(negedge sys_clk);
        smp(x, 2'd0, x, -x);
        timeout_clock_enable = 1'b0;
        wr(ADDR_SPK_VOL, RST_SPK_VOL);
        wr(ADDR_LIM_TIMING, 9'h100);
        repeat (300) smp(24'sh7f_0000, 2'd1, 24'sd0, 24'sd0);
        smp(24'sh7f_0000, 2'd2, 24'sh7f_0000, 24'sd0);
        wr(ADDR_LIM_TIMING, RST_LIM_TIMING);
        smp(x, 2'd0, x, -x);
        repeat (3) @(negedge sys_clk);
        `CHK("shift_fault", 1'b0, shift_fault)
        report_and_stop();
    end
endmodule // tb_dlo_limiter_output

//--- verilog/dlo_limiter_output.sv
// playback limiter, boost, speaker mixer, volume and output stage control.
// assumes aligned dac, bypass and mic2 samples, one per in_valid.
// assumes registers written by the serial control decoder.

////////////////////////////////////////////////////////////////////////////////
// Contract
// - boost 0 to 12 dB, 1 dB steps
// - limiter on: boost quiet signals by boost
// - limiter off: boost is a fixed gain
// - attack field 94us per 6 dB, doubling
// - decay field 750us per 6 dB, doubling
// - times scale with actual sample rate
// - limiter enable bit 8, reset off
// - threshold -1 to -6 dB, 3-bit field
// - speaker stage boost bit 2: 1.5x
// - mono stage boost bit 3: 1.5x
// - boost shifts dc level, non-inverting stage
// - speaker mixer source select bits 0,1,5
// - bypass into speaker mixer -10 dB option
// - speaker volume 6-bit, 1 dB steps
// - zero-cross volume update when bit 7 set
// - speaker mute drives mid-rail level
// - negative output is inverse of positive
// - thresholds 0.5 dB either side of level
// - attack above upper, decay below lower
// - zero-cross timeout after 2^21 clocks
module dlo_limiter_output
    import dlo_pkg::*;
#(
    parameter int ZC_TIMEOUT_CYCLES = ZC_TIMEOUT_DEFAULT
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // register access
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [6:0] reg_addr,
    input wire logic [8:0] reg_wdata,
    output logic [8:0] reg_rdata,
    // zero-cross timeout enable
    input wire logic timeout_clock_enable,
    // sample stream in
    input wire logic in_valid,
    input wire logic signed [23:0] in_sample,
    input wire logic signed [23:0] bypass_sample,
    input wire logic signed [23:0] mic2_sample,
    // limited dac stream out
    output logic out_valid,
    output logic signed [23:0] out_sample,
    // speaker outputs, zero at mid-rail
    output logic signed [23:0] speaker_out_positive,
    output logic signed [23:0] speaker_out_negative,
    // output stage controls
    output logic speaker_stage_gain_boost,
    output logic mono_stage_gain_boost,
    output logic dc_shift_buffer_enable
);

    if (ZC_TIMEOUT_CYCLES < 1 || ZC_TIMEOUT_CYCLES > 4194303) begin : g_zc_check
        $error("ZC_TIMEOUT_CYCLES must fit a 22-bit counter");
    end

    localparam logic [21:0] ZC_LAST = 22'(ZC_TIMEOUT_CYCLES - 1);

    ////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic [8:0] power_control_one;
        logic [8:0] limiter_timing_control;
        logic [8:0] limiter_level_control;
        logic [8:0] bypass_attenuation_control;
        logic [8:0] output_stage_control;
        logic [8:0] speaker_mixer_select;
        logic [8:0] speaker_volume_control;

        logic [19:0] lim_att;
        logic [5:0] vol_applied;
        logic prev_neg;
        logic [21:0] zc_timer;

        logic [8:0] rdata;
        logic out_valid;
        logic signed [23:0] out_sample;
        logic signed [23:0] spk_p;
        logic signed [23:0] spk_n;
    } dlo_state_t;

    dlo_state_t st_r;
    dlo_state_t st_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic signed [23:0] sat24(input logic signed [40:0] v);
        if (v > 41'sh7f_ffff) begin
            return 24'sh7f_ffff;
        end else if (v < -41'sh80_0000) begin
            return -24'sh80_0000;
        end else begin
            return v[23:0];
        end
    endfunction

    // Q15 multiplier of gain/4, up to +12 dB
    function automatic logic [15:0] gain_mult(input logic signed [15:0] net);
        logic signed [16:0] n;
        logic [3:0] sh;
        logic [3:0] idx;
        n = HEADROOM_UNITS - 17'(net);
        if (n < 0) begin
            n = '0;
        end
        sh = 4'(n / UNITS_PER_6DB);
        idx = 4'((n % UNITS_PER_6DB) / UNITS_PER_HALF_DB);
        return gain_step(idx) >> sh;
    endfunction

    function automatic logic signed [23:0] apply_gain(input logic signed [23:0] s,
                                                      input logic signed [15:0] net);
        logic [15:0] m;
        logic signed [40:0] p;
        m = gain_mult(net);
        p = 41'(s) * 41'($signed({1'b0, m}));
        // gain/4 multiplier: shift by 13, not 15
        return sat24(p >>> 13);
    endfunction

    function automatic logic [19:0] rate_inc(input logic [19:0] base, input logic [3:0] code);
        logic [3:0] c;
        c = (code > RATE_SAT_CODE) ? RATE_SAT_CODE : code;
        return base >> c;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // next state

    logic [3:0] boost_code;
    logic [2:0] lvl_idx;

    logic [15:0] boost_units;
    logic signed [15:0] lim_net;
    logic signed [23:0] limited;

    logic [23:0] lim_mag;
    logic [23:0] thr_upper;
    logic [23:0] thr_lower;
    logic [19:0] atk_inc;
    logic [19:0] dcy_inc;
    logic [20:0] att_up;

    logic signed [23:0] byp_term;
    logic signed [25:0] mix_sum;
    logic signed [23:0] mix;

    logic zero_cross;
    logic vol_pending;
    logic signed [15:0] vol_net;
    logic signed [23:0] vol_out;
    logic signed [23:0] muted;

    logic signed [40:0] stage_w;
    logic signed [23:0] stage_out;

    always_comb begin
        st_nxt = st_r;
        st_nxt.out_valid = 1'b0;


        // unmapped writes ignored
        if (reg_wr_en) begin
            unique case (reg_addr)
                ADDR_POWER_ONE: st_nxt.power_control_one = reg_wdata;
                ADDR_LIM_TIMING: st_nxt.limiter_timing_control = reg_wdata;
                ADDR_LIM_LEVEL: st_nxt.limiter_level_control = reg_wdata;
                ADDR_BYP_ATTN: st_nxt.bypass_attenuation_control = reg_wdata;
                ADDR_OUT_STAGE: st_nxt.output_stage_control = reg_wdata;
                ADDR_SPK_MIX: st_nxt.speaker_mixer_select = reg_wdata;
                ADDR_SPK_VOL: st_nxt.speaker_volume_control = reg_wdata;
                default: ;
            endcase
        end

        // unmapped reads give zero
        if (reg_rd_en) begin
            unique case (reg_addr)
                ADDR_POWER_ONE: st_nxt.rdata = st_r.power_control_one;
                ADDR_LIM_TIMING: st_nxt.rdata = st_r.limiter_timing_control;
                ADDR_LIM_LEVEL: st_nxt.rdata = st_r.limiter_level_control;
                ADDR_BYP_ATTN: st_nxt.rdata = st_r.bypass_attenuation_control;
                ADDR_OUT_STAGE: st_nxt.rdata = st_r.output_stage_control;
                ADDR_SPK_MIX: st_nxt.rdata = st_r.speaker_mixer_select;
                ADDR_SPK_VOL: st_nxt.rdata = st_r.speaker_volume_control;
                default: st_nxt.rdata = '0;
            endcase
        end

        // boost minus running attenuation
        boost_code = st_r.limiter_level_control[BOOST_LSB +: 4];
        if (boost_code > BOOST_MAX_CODE) begin
            boost_code = BOOST_MAX_CODE;
        end
        boost_units = 16'(boost_code) * 16'(UNITS_PER_DB);
        lim_net = $signed(boost_units);
        if (st_r.limiter_timing_control[LIMITER_ENABLE_BIT]) begin
            lim_net = lim_net - $signed({4'h0, st_r.lim_att[19:8]});
        end
        limited = apply_gain(in_sample, lim_net);
        lim_mag = limited[23] ? 24'(-limited) : 24'(limited);
        if (lim_mag[23]) begin
            lim_mag = 24'h7f_ffff;
        end

        lvl_idx = st_r.limiter_level_control[LVL_LSB +: 3];
        if (lvl_idx > LVL_MAX_IDX) begin
            lvl_idx = LVL_MAX_IDX;
        end
        thr_upper = level_thr(lvl_idx);
        thr_lower = level_thr(lvl_idx + 3'h1);


        // per-sample stepping tracks the sample rate
        atk_inc = rate_inc(ATK_INC_BASE, st_r.limiter_timing_control[ATK_LSB +: 4]);
        dcy_inc = rate_inc(DCY_INC_BASE, st_r.limiter_timing_control[DCY_LSB +: 4]);
        att_up = {1'b0, st_r.lim_att} + {1'b0, atk_inc};


        // speaker mixer
        if (st_r.bypass_attenuation_control[SPK_ATTN_BIT]) begin
            byp_term = apply_gain(bypass_sample, BYP_ATTN_UNITS);
        end else begin
            byp_term = bypass_sample;
        end

        mix_sum = '0;
        if (st_r.speaker_mixer_select[DAC_MIX_BIT]) begin
            mix_sum = mix_sum + 26'(limited);
        end
        if (st_r.speaker_mixer_select[BYP_MIX_BIT]) begin
            mix_sum = mix_sum + 26'(byp_term);
        end
        if (st_r.speaker_mixer_select[MIC_MIX_BIT]) begin
            mix_sum = mix_sum + 26'(mic2_sample);
        end
        mix = sat24(41'(mix_sum));

        zero_cross = (mix[23] != st_r.prev_neg) || (mix == '0);

        // speaker volume, 0 dB at code 57
        vol_net = 16'(($signed({10'h000, st_r.vol_applied}) - $signed({10'h000, VOL_ZERO_DB_CODE}))
                  * 16'sd64);
        vol_out = apply_gain(mix, vol_net);
        muted = st_r.speaker_volume_control[MUTE_BIT] ? 24'sh00_0000 : vol_out;

        // inverting unity or 1.5x non-inverting stage
        if (st_r.output_stage_control[SPK_BOOST_BIT]) begin
            stage_w = 41'(muted) + 41'(muted >>> 1);
        end else begin
            stage_w = -41'(muted);
        end
        stage_out = sat24(stage_w);

        vol_pending = st_r.vol_applied != st_r.speaker_volume_control[VOL_LSB +: 6];

        if (in_valid) begin
            st_nxt.out_valid = 1'b1;
            st_nxt.out_sample = limited;
            st_nxt.prev_neg = mix[23];
            st_nxt.spk_p = stage_out;
            st_nxt.spk_n = sat24(-41'(stage_out));
            if (st_r.limiter_timing_control[LIMITER_ENABLE_BIT]) begin
                if (lim_mag > thr_upper) begin
                    st_nxt.lim_att = (att_up > {1'b0, ATT_MAX}) ? ATT_MAX : att_up[19:0];
                end else if (lim_mag < thr_lower) begin
                    st_nxt.lim_att = (st_r.lim_att > dcy_inc) ? st_r.lim_att - dcy_inc : '0;
                end
            end else begin
                st_nxt.lim_att = '0;
            end
        end

        // volume update
        st_nxt.zc_timer = '0;
        if (vol_pending) begin
            if (!st_r.speaker_volume_control[ZC_BIT]) begin
                st_nxt.vol_applied = st_r.speaker_volume_control[VOL_LSB +: 6];
            end else if (in_valid && zero_cross) begin
                st_nxt.vol_applied = st_r.speaker_volume_control[VOL_LSB +: 6];
            end else if (timeout_clock_enable) begin
                if (st_r.zc_timer == ZC_LAST) begin
                    st_nxt.vol_applied = st_r.speaker_volume_control[VOL_LSB +: 6];
                end else begin
                    st_nxt.zc_timer = st_r.zc_timer + 22'h1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_r.power_control_one <= RST_POWER_ONE;
            st_r.limiter_timing_control <= RST_LIM_TIMING;
            st_r.limiter_level_control <= RST_LIM_LEVEL;
            st_r.bypass_attenuation_control <= RST_BYP_ATTN;
            st_r.output_stage_control <= RST_OUT_STAGE;
            st_r.speaker_mixer_select <= RST_SPK_MIX;
            st_r.speaker_volume_control <= RST_SPK_VOL;

            st_r.lim_att <= '0;
            st_r.vol_applied <= RST_SPK_VOL[VOL_LSB +: 6];
            st_r.prev_neg <= 1'b0;
            st_r.zc_timer <= '0;

            st_r.rdata <= '0;
            st_r.out_valid <= 1'b0;
            st_r.out_sample <= '0;
            st_r.spk_p <= '0;
            st_r.spk_n <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign reg_rdata = st_r.rdata;
    assign out_valid = st_r.out_valid;
    assign out_sample = st_r.out_sample;
    assign speaker_out_positive = st_r.spk_p;
    assign speaker_out_negative = st_r.spk_n;

    assign speaker_stage_gain_boost = st_r.output_stage_control[SPK_BOOST_BIT];
    assign mono_stage_gain_boost = st_r.output_stage_control[MONO_BOOST_BIT];
    // boost clips unless software set this first
    assign dc_shift_buffer_enable = st_r.power_control_one[DCBUF_BIT];

endmodule // dlo_limiter_output
